// ### logic/fdc_status_defines.svh
// Bit positions, codes and limits of the result-phase status bytes.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef FDC_STATUS_DEFINES_SVH
`define FDC_STATUS_DEFINES_SVH

// First status byte
`define ST0_CLASS_HI 7
`define ST0_CLASS_LO 6
`define ST0_SEEK_BIT 5
`define ST0_EQUIP_BIT 4
`define ST0_HEAD_BIT 2
// Second status byte
`define ST1_EOT_BIT 7
`define ST1_CRC_BIT 5
`define ST1_OVR_BIT 4
`define ST1_NOSECT_BIT 2
`define ST1_WPROT_BIT 1
`define ST1_AMARK_BIT 0
`define ST1_USED_MASK 8'hB7
// Third status byte
`define ST2_CTRL_BIT 6
`define ST2_CRC_BIT 5
`define ST2_TRKMIS_BIT 4
`define ST2_BADTRK_BIT 1
`define ST2_DMARK_BIT 0
`define ST2_USED_MASK 8'h73
// Completion class codes
`define CLASS_NORMAL 2'h0
`define CLASS_ABNORMAL 2'h1
`define CLASS_INVALID 2'h2
`define CLASS_POLLED 2'h3
// Limits
`define RECAL_STEP_LIMIT 7'h50
`define LAST_SECTOR_NUM 8'hFF
`define BAD_TRACK_ID 8'hFF
`define ID_INDEX_LIMIT 2'h2
`define RESULT_BYTES_MAX 2'h3

`endif

// ### logic/fdc_status_pkg.sv
// Types shared by the status encoder and its result reader.
// Assumes nothing of its surroundings.
package fdc_status_pkg;

  // Command being executed, as told by the command decoder
  typedef enum logic [3:0] {
    CMD_OTHER, CMD_READ_DATA, CMD_READ_DELETED, CMD_WRITE_DATA,
    CMD_WRITE_DELETED, CMD_FORMAT, CMD_READ_ID, CMD_READ_TRACK,
    CMD_SEEK, CMD_REL_SEEK, CMD_RECAL, CMD_SENSE_INT
  } cmd_kind_t;

  // Result reader states
  typedef enum logic {RD_IDLE, RD_SHOW} rd_state_t;

  // Data read commands that search for a sector
  function automatic logic is_read_kind(input cmd_kind_t k);
    return (k == CMD_READ_DATA) || (k == CMD_READ_DELETED);
  endfunction

  // Commands that write to the medium
  function automatic logic is_write_kind(input cmd_kind_t k);
    return (k == CMD_WRITE_DATA) || (k == CMD_WRITE_DELETED) ||
           (k == CMD_FORMAT);
  endfunction

endpackage

// ### logic/fdc_status_if.sv
// Carries the three assembled status bytes from encoder to reader.
// Assumes one source and one sink in the same clock domain.
`timescale 1ns/100ps
`default_nettype none

interface fdc_status_if;
  logic [7:0] st0;
  logic [7:0] st1;
  logic [7:0] st2;
  modport source (output st0, output st1, output st2);
  modport sink (input st0, input st1, input st2);
endinterface

`default_nettype wire

// ### logic/fdc_flag_bank.sv
// Bank of sticky flags with per-bit clear; a set beats a clear.
// Assumes set and clear are synchronous one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none

module fdc_flag_bank #(
  parameter int WIDTH = 18
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  // Set wins over clear in the same cycle
  assign flags_d = (flags_q & ~clr_i) | set_i;
  assign flags_o = flags_q;

  // Flags hold while the clock enable is low
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      flags_q <= '0;
    end else if (clk_en_i) begin
      flags_q <= flags_d;
    end
  end

endmodule

`default_nettype wire

// ### logic/fdc_result_reader.sv
// Presents the status bytes one by one through the data register.
// Assumes the host reads with a one-cycle strobe while valid is high.
`timescale 1ns/100ps
`default_nettype none

module fdc_result_reader
  import fdc_status_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire logic [1:0] count_i,
  input wire logic rd_i,
  fdc_status_if.sink st,
  output logic [7:0] data_o,
  output logic valid_o,
  output logic last_o,
  output logic done_o
);

  rd_state_t state_q;
  logic [1:0] idx_q;
  logic [1:0] count_q;
  logic [7:0] data_q;
  wire take = valid_o & rd_i & clk_en_i;
  wire [1:0] idx_nx = idx_q + 2'h1;
  wire [7:0] next_byte = (idx_nx == 2'h1) ? st.st1 : st.st2;
  wire [1:0] count_lim = (count_i == 2'h0) ? 2'h1 : count_i;

  // Handshake outputs
  assign valid_o = (state_q == RD_SHOW);
  assign last_o = valid_o && (idx_nx == count_q);
  assign done_o = take & last_o;
  assign data_o = data_q;

  // Byte sequencing in order first, second, third
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= RD_IDLE;
      idx_q <= 2'h0;
      count_q <= 2'h0;
      data_q <= 8'h00;
    end else if (clk_en_i) begin
      case (state_q)
        RD_IDLE: begin
          if (start_i) begin
            state_q <= RD_SHOW;
            idx_q <= 2'h0;
            count_q <= count_lim;
            data_q <= st.st0;
          end
        end
        RD_SHOW: begin
          if (take && last_o) begin
            state_q <= RD_IDLE;
          end else if (take) begin
            idx_q <= idx_nx;
            data_q <= next_byte;
          end
        end
        default: state_q <= RD_IDLE;
      endcase
    end
  end

  a_first_byte_shown: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && start_i && state_q == RD_IDLE) |=>
      (valid_o && data_o == $past(st.st0)))
    else $error("first status byte not presented");

endmodule

`default_nettype wire

// ### logic/fdc_result_status_encoder.sv
// Result-phase status byte encoder of the floppy controller core.
// Assumes the execution engine reports events as one-cycle pulses
// and the host reads bytes with a strobe; all inputs synchronous.
//
// What this block does
// - Status bytes are presented one after another through the data port.
// - Class bits 7:6 read 00 on success, 01 on failed execution.
// - Class reads 10 for invalid command, 11 for polling abort.
// - First byte bit 5 marks a finished seek, relative seek or recalibrate.
// - Bit 4 set when track zero is absent after 80 recalibrate steps.
// - Bit 4 also set when relative seek steps outward past track zero.
// - Bit 2 shows current head, bits 1:0 the selected drive.
// - Unused bit positions of all three bytes always read zero.
// - Second byte bit 7 set on access past last sector 255.
// - Missing terminal count at end of read or write data sets bit 7.
// - Second byte bit 5 set on CRC error in ID or data field.
// - Second byte bit 4 set on overrun or underrun.
// - Bit 2 set on missing sector, bad ID read or wrong sequence.
// - Bit 1 set when write protect rises during a write operation.
// - Bit 0 set when no ID mark seen after two index pulses.
// - Missing data mark sets bit 0 of second and third bytes.
// - Third byte bit 6 set on opposite kind of data mark.
// - Third byte bit 5 set on CRC error in the data field.
// - Third byte bit 4 set when ID track differs from internal track.
// - Third byte bit 1 set when differing ID track equals FF.
`timescale 1ns/100ps
`default_nettype none
`include "fdc_status_defines.svh"

module fdc_result_status_encoder
  import fdc_status_pkg::*;
#(
  parameter int STEP_CNT_W = 7
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic cmd_start_i,
  input wire cmd_kind_t cmd_kind_i,
  input wire logic exec_end_i,
  input wire logic invalid_cmd_i,
  input wire logic poll_abort_i,
  input wire logic seek_done_i,
  input wire logic step_pulse_i,
  input wire logic step_outward_i,
  input wire logic track_zero_input_i,
  input wire logic head_i,
  input wire logic [1:0] drive_number_i,
  input wire logic [7:0] cur_track_i,
  input wire logic sector_advance_i,
  input wire logic [7:0] sector_num_i,
  input wire logic terminal_count_i,
  input wire logic crc_id_err_i,
  input wire logic crc_data_err_i,
  input wire logic overrun_i,
  input wire logic sector_missing_i,
  input wire logic id_field_err_i,
  input wire logic sequence_err_i,
  input wire logic write_prot_i,
  input wire logic id_search_i,
  input wire logic index_pulse_input_i,
  input wire logic id_mark_found_i,
  input wire logic data_mark_absent_i,
  input wire logic data_mark_found_i,
  input wire logic data_mark_deleted_i,
  input wire logic id_read_i,
  input wire logic [7:0] id_track_i,
  input wire logic result_start_i,
  input wire logic [1:0] result_count_i,
  input wire logic result_rd_i,
  output logic [7:0] result_byte_o,
  output logic result_valid_o,
  output logic result_last_o,
  output logic result_done_o,
  output logic busy_o
);

  fdc_status_if st_if ();

  cmd_kind_t kind_q;
  logic executing_q;
  logic tc_seen_q;
  logic wp_last_q;
  logic [1:0] class_q;
  logic [1:0] class_d;
  logic [STEP_CNT_W-1:0] recal_steps_q;
  logic [1:0] index_cnt_q;
  logic [17:0] flags;
  logic [17:0] flag_set;
  logic [17:0] flag_clr;
  logic [7:0] st1_set;
  logic [7:0] st2_set;

  // Command qualifiers
  wire start_en = clk_en_i & cmd_start_i;
  wire keeps_st0 = (cmd_kind_i == CMD_SENSE_INT);
  wire in_read = executing_q & is_read_kind(kind_q);
  wire in_write = executing_q & is_write_kind(kind_q);
  wire in_rw = executing_q &
               ((kind_q == CMD_READ_DATA) || (kind_q == CMD_WRITE_DATA));
  wire in_recal = executing_q & (kind_q == CMD_RECAL);
  wire in_rel_seek = executing_q & (kind_q == CMD_REL_SEEK);

  // Equipment check conditions
  wire recal_fail = in_recal & exec_end_i & ~track_zero_input_i &
    (recal_steps_q >= STEP_CNT_W'(`RECAL_STEP_LIMIT));
  wire rel_outward = in_rel_seek & step_pulse_i & step_outward_i &
                     track_zero_input_i;
  wire equip_set = recal_fail | rel_outward;

  // Second byte conditions
  wire past_last = executing_q & sector_advance_i &
                   (sector_num_i == `LAST_SECTOR_NUM);
  wire no_tc = in_rw & exec_end_i & ~tc_seen_q & ~terminal_count_i;
  wire crc_any = executing_q & (crc_id_err_i | crc_data_err_i);
  wire no_sector = (in_read & sector_missing_i) |
    (executing_q & (kind_q == CMD_READ_ID) & id_field_err_i) |
    (executing_q & (kind_q == CMD_READ_TRACK) & sequence_err_i);
  wire wp_rise = in_write & write_prot_i & ~wp_last_q;
  wire index_twice = executing_q & id_search_i & index_pulse_input_i &
    ~id_mark_found_i & (index_cnt_q == `ID_INDEX_LIMIT - 2'h1);
  wire dmark_gone = executing_q & data_mark_absent_i;

  // Third byte conditions
  wire ctrl_mark = executing_q & data_mark_found_i &
    (((kind_q == CMD_READ_DATA) & data_mark_deleted_i) |
     ((kind_q == CMD_READ_DELETED) & ~data_mark_deleted_i));
  wire trk_differs = executing_q & id_read_i &
                     (id_track_i != cur_track_i);
  wire trk_bad = trk_differs & (id_track_i == `BAD_TRACK_ID);

  // Set vectors for the second and third bytes
  always_comb begin
    st1_set = 8'h00;
    st1_set[`ST1_EOT_BIT] = past_last | no_tc;
    st1_set[`ST1_CRC_BIT] = crc_any;
    st1_set[`ST1_OVR_BIT] = executing_q & overrun_i;
    st1_set[`ST1_NOSECT_BIT] = no_sector;
    st1_set[`ST1_WPROT_BIT] = wp_rise;
    st1_set[`ST1_AMARK_BIT] = index_twice | dmark_gone;
    st2_set = 8'h00;
    st2_set[`ST2_CTRL_BIT] = ctrl_mark;
    st2_set[`ST2_CRC_BIT] = executing_q & crc_data_err_i;
    st2_set[`ST2_TRKMIS_BIT] = trk_differs;
    st2_set[`ST2_BADTRK_BIT] = trk_bad;
    st2_set[`ST2_DMARK_BIT] = dmark_gone;
  end

  // Seek and equipment bits survive a sense-interrupt command start
  assign flag_set = {equip_set, executing_q & seek_done_i, st2_set, st1_set};
  assign flag_clr = {{2{start_en & ~keeps_st0}}, {16{start_en}}};

  fdc_flag_bank #(
    .WIDTH(18)
  ) u_flags (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .clk_en_i(clk_en_i),
    .set_i(flag_set),
    .clr_i(flag_clr),
    .flags_o(flags)
  );

  // Completion class: explicit codes first, then any fault
  wire any_fault = (|flags[15:0]) | flags[17];
  wire [1:0] completion_class = (class_q != `CLASS_NORMAL) ? class_q :
    (any_fault ? `CLASS_ABNORMAL : `CLASS_NORMAL);
  assign class_d = invalid_cmd_i ? `CLASS_INVALID :
                   poll_abort_i ? `CLASS_POLLED :
                   (cmd_start_i & ~keeps_st0) ? `CLASS_NORMAL : class_q;

  // Assembled bytes with unused positions forced to zero
  always_comb begin
    st_if.st0 = 8'h00;
    st_if.st0[`ST0_CLASS_HI:`ST0_CLASS_LO] = completion_class;
    st_if.st0[`ST0_SEEK_BIT] = flags[16];
    st_if.st0[`ST0_EQUIP_BIT] = flags[17];
    st_if.st0[`ST0_HEAD_BIT] = head_i;
    st_if.st0[1:0] = drive_number_i;
    st_if.st1 = flags[7:0] & `ST1_USED_MASK;
    st_if.st2 = flags[15:8] & `ST2_USED_MASK;
  end

  // Command context and execution tracking
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      kind_q <= CMD_OTHER;
      executing_q <= 1'b0;
      class_q <= `CLASS_NORMAL;
    end else if (clk_en_i) begin
      class_q <= class_d;
      if (cmd_start_i) begin
        kind_q <= cmd_kind_i;
        executing_q <= 1'b1;
      end else if (exec_end_i | invalid_cmd_i | poll_abort_i) begin
        executing_q <= 1'b0;
      end
    end
  end

  // Terminal count seen and write-protect edge history
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tc_seen_q <= 1'b0;
      wp_last_q <= 1'b0;
    end else if (clk_en_i) begin
      // A count arriving with the start still counts for the new command
      tc_seen_q <= (tc_seen_q & ~cmd_start_i) | terminal_count_i;
      wp_last_q <= write_prot_i;
    end
  end

  // Recalibrate step counter, saturating at the limit
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      recal_steps_q <= '0;
    end else if (clk_en_i) begin
      if (cmd_start_i) begin
        recal_steps_q <= '0;
      end else if (in_recal && step_pulse_i &&
                   recal_steps_q < STEP_CNT_W'(`RECAL_STEP_LIMIT)) begin
        recal_steps_q <= recal_steps_q + STEP_CNT_W'(1);
      end
    end
  end

  // Index pulses seen while hunting an ID mark
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      index_cnt_q <= 2'h0;
    end else if (clk_en_i) begin
      if (cmd_start_i || !id_search_i || id_mark_found_i) begin
        index_cnt_q <= 2'h0;
      end else if (index_pulse_input_i &&
                   index_cnt_q < `ID_INDEX_LIMIT) begin
        index_cnt_q <= index_cnt_q + 2'h1;
      end
    end
  end

  fdc_result_reader u_reader (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .clk_en_i(clk_en_i),
    .start_i(result_start_i),
    .count_i(result_count_i),
    .rd_i(result_rd_i),
    .st(st_if.sink),
    .data_o(result_byte_o),
    .valid_o(result_valid_o),
    .last_o(result_last_o),
    .done_o(result_done_o)
  );

  assign busy_o = executing_q;

  a_class_invalid: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && invalid_cmd_i) |=> (st_if.st0[7:6] == 2'h2))
    else $error("invalid command class not 10");

  a_class_abnormal: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (class_q == 2'h0 && flags[7:0] != 8'h00) |->
      (st_if.st0[7:6] == 2'h1))
    else $error("fault without abnormal class");

  a_seek_reported: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && executing_q && seek_done_i) |=> st_if.st0[5])
    else $error("seek end not reported");

  a_recal_fault: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && in_recal && exec_end_i && !track_zero_input_i &&
     recal_steps_q == STEP_CNT_W'(`RECAL_STEP_LIMIT)) |=> st_if.st0[4])
    else $error("recalibrate fault missed after 80 steps");

  a_unused_zero: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (st_if.st0[3] == 1'b0) && ((st_if.st1 & 8'h48) == 8'h00) &&
    ((st_if.st2 & 8'h8C) == 8'h00))
    else $error("unused status bit nonzero");

  a_eot_no_tc: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && in_rw && exec_end_i && !tc_seen_q && !terminal_count_i)
      |=> st_if.st1[7])
    else $error("end of track not set without terminal count");

  a_crc_data: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && executing_q && crc_data_err_i) |=>
      (st_if.st1[5] && st_if.st2[5]))
    else $error("data field crc not flagged in both bytes");

  a_index_twice: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && executing_q && id_search_i && !id_mark_found_i &&
     index_pulse_input_i && index_cnt_q == 2'h1) |=> st_if.st1[0])
    else $error("missing id mark not flagged");

  a_bad_track: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && executing_q && id_read_i && id_track_i == 8'hFF &&
     cur_track_i != 8'hFF) |=> (st_if.st2[4] && st_if.st2[1]))
    else $error("bad track not flagged");

  a_start_clears: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && cmd_start_i && !executing_q) |=>
      (st_if.st1 == 8'h00 && st_if.st2 == 8'h00))
    else $error("flags not cleared at command start");

endmodule

`default_nettype wire

// ### dv/fdc_host_reader.sv
// Host model that reads result bytes from the status encoder.
// Assumes the bench seeds the random source before the first read.
`timescale 1ns/100ps
`default_nettype none

module fdc_host_reader (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic valid_i,
  input wire logic last_i,
  input wire logic done_i,
  input wire logic [7:0] byte_i,
  output logic rd_o,
  output logic got_o,
  output logic [9:0] got_data_o
);
  initial begin
    rd_o = 1'b0;
    got_o = 1'b0;
    got_data_o = 10'h000;
  end

  // Read strobe, sometimes at once and sometimes after a stall
  always @(negedge core_clk_i) begin
    rd_o <= !srst_i && valid_i && ($urandom_range(2) != 0);
  end

  // Capture each byte taken, with its last and done marks
  always @(posedge core_clk_i) begin
    got_o <= rd_o && valid_i;
    got_data_o <= {done_i, last_i, byte_i};
  end
endmodule

`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the result status encoder.
// Assumes the host model reads every byte that becomes valid.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import fdc_status_pkg::*;
  logic core_clk_i = 0, srst_i = 1, clk_en_i = 1, cmd_start_i = 0;
  cmd_kind_t cmd_kind_i = CMD_OTHER;
  logic exec_end_i = 0, invalid_cmd_i = 0, poll_abort_i = 0;
  logic seek_done_i = 0, step_pulse_i = 0, step_outward_i = 0;
  logic track_zero_input_i = 0, head_i = 0, terminal_count_i = 0;
  logic [1:0] drive_number_i = 2'h0, result_count_i = 2'h3;
  logic [7:0] cur_track_i = 8'h00, id_track_i = 8'h00, result_byte_o;
  logic [7:0] sector_num_i = 8'h00;
  logic sector_advance_i = 0, crc_id_err_i = 0, crc_data_err_i = 0;
  logic overrun_i = 0, sector_missing_i = 0, id_field_err_i = 0;
  logic sequence_err_i = 0, write_prot_i = 0, id_search_i = 0;
  logic index_pulse_input_i = 0, id_mark_found_i = 0;
  logic data_mark_absent_i = 0, data_mark_found_i = 0;
  logic data_mark_deleted_i = 0, id_read_i = 0, result_start_i = 0;
  logic result_rd_i, result_valid_o, result_last_o, result_done_o;
  logic busy_o, got;
  logic [9:0] got_data;
  logic [9:0] exp_q[$];
  int failures = 0, samples_checked = 0;

  always #2 core_clk_i = ~core_clk_i;

  fdc_result_status_encoder dut (.core_clk_i, .srst_i, .clk_en_i,
    .cmd_start_i, .cmd_kind_i, .exec_end_i, .invalid_cmd_i,
    .poll_abort_i, .seek_done_i, .step_pulse_i, .step_outward_i,
    .track_zero_input_i, .head_i, .drive_number_i, .cur_track_i,
    .sector_advance_i, .sector_num_i, .terminal_count_i, .crc_id_err_i,
    .crc_data_err_i, .overrun_i, .sector_missing_i, .id_field_err_i,
    .sequence_err_i, .write_prot_i, .id_search_i, .index_pulse_input_i,
    .id_mark_found_i, .data_mark_absent_i, .data_mark_found_i,
    .data_mark_deleted_i, .id_read_i, .id_track_i, .result_start_i,
    .result_count_i, .result_rd_i, .result_byte_o, .result_valid_o,
    .result_last_o, .result_done_o, .busy_o);

  fdc_host_reader host (.core_clk_i, .srst_i, .valid_i(result_valid_o),
    .last_i(result_last_o), .done_i(result_done_o),
    .byte_i(result_byte_o), .rd_o(result_rd_i), .got_o(got),
    .got_data_o(got_data));

  task give_verdict;
    $display("Counts: %0d checked, %0d mismatched", samples_checked,
             failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task miss(input string m);
    failures++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask

  task chk(input logic [9:0] a, input logic [9:0] e, input string m);
    samples_checked++;
    if (a !== e) begin
      miss(m);
    end
  endtask

  task tick;
    @(negedge core_clk_i);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask

  // Bounded wait for the busy level
  task wait_busy(input logic lvl);
    int n;
    for (n = 0; n < 50 && busy_o !== lvl; n++) tick;
    if (busy_o !== lvl) begin
      miss("busy never reached its level");
      give_verdict;
    end
  endtask

  // Drives one execution event or event sequence
  task fire(input int e);
    int i;
    case (e)
      1: pulse(crc_data_err_i);
      2: pulse(crc_id_err_i);
      3: pulse(overrun_i);
      4: pulse(sector_missing_i);
      5: pulse(id_field_err_i);
      6: pulse(sequence_err_i);
      7: pulse(data_mark_absent_i);
      8, 9: begin
        data_mark_deleted_i = (e == 8);
        pulse(data_mark_found_i);
      end
      10, 11, 20: begin
        id_track_i = (e == 11) ? 8'hFF :
                     (e == 10) ? cur_track_i + 8'h01 : cur_track_i;
        pulse(id_read_i);
      end
      12: begin
        write_prot_i = 1'b1;
        tick;
      end
      13: begin
        id_search_i = 1'b1;
        tick;
        pulse(index_pulse_input_i);
        tick;
        pulse(index_pulse_input_i);
        tick;
        id_search_i = 1'b0;
      end
      14: pulse(seek_done_i);
      15, 16: for (i = 0; i < ((e == 15) ? 80 : 79); i++) begin
        pulse(step_pulse_i);
        tick;
      end
      17: begin
        track_zero_input_i = 1'b1;
        step_outward_i = 1'b1;
        pulse(step_pulse_i);
      end
      18: pulse(invalid_cmd_i);
      19: pulse(poll_abort_i);
      23, 24: begin
        sector_num_i = (e == 23) ? 8'hFF : 8'($urandom_range(254));
        pulse(sector_advance_i);
      end
      25: begin
        id_search_i = 1'b1;
        pulse(index_pulse_input_i);
        pulse(id_mark_found_i);
        pulse(index_pulse_input_i);
        id_search_i = 1'b0;
      end
      22: begin
        clk_en_i = 1'b0;
        pulse(crc_data_err_i);
        clk_en_i = 1'b1;
      end
      default: tick;
    endcase
  endtask

  // One command, then its result phase read by the host model
  task t(input cmd_kind_t k, input int e, input logic [7:0] s0,
         input logic [7:0] s1, input logic [7:0] s2);
    int n;
    write_prot_i = 1'b0;
    track_zero_input_i = 1'b0;
    step_outward_i = 1'b0;
    head_i = 1'($urandom);
    drive_number_i = 2'($urandom);
    cur_track_i = 8'($urandom_range(253));
    cmd_kind_i = k;
    pulse(cmd_start_i);
    wait_busy(1'b1);
    fire(e);
    if (e != 21) pulse(terminal_count_i);
    if (e < 18 || e > 19) pulse(exec_end_i);
    wait_busy(1'b0);
    n = (result_count_i == 2'h1);
    exp_q.push_back({n[0], n[0], s0 | {5'h00, head_i, drive_number_i}});
    if (n == 0) begin
      exp_q.push_back({2'h0, s1});
      exp_q.push_back({2'h3, s2});
    end
    pulse(result_start_i);
    for (n = 0; n < 200 && exp_q.size() > 0; n++) tick;
    if (exp_q.size() > 0) begin
      miss("result bytes not all read");
      give_verdict;
    end
    $display("Test done: kind %0d event %0d", k, e);
  endtask

  // Compares each byte the host took with the oldest expectation
  always @(negedge core_clk_i) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) miss("unexpected result byte");
      else chk(got_data, exp_q.pop_front(), "status byte");
    end
  end

  initial begin
    void'($urandom(32'h00008E21));
    repeat (10) tick;
    chk({busy_o, result_valid_o, result_byte_o}, 10'h000, "reset");
    srst_i = 1'b0;
    t(CMD_READ_DATA, 1, 8'h40, 8'h20, 8'h20);
    t(CMD_OTHER, 0, 8'h00, 8'h00, 8'h00);
    t(CMD_READ_DATA, 2, 8'h40, 8'h20, 8'h00);
    t(CMD_READ_DATA, 3, 8'h40, 8'h10, 8'h00);
    t(CMD_READ_DATA, 4, 8'h40, 8'h04, 8'h00);
    t(CMD_READ_ID, 5, 8'h40, 8'h04, 8'h00);
    t(CMD_READ_TRACK, 6, 8'h40, 8'h04, 8'h00);
    t(CMD_READ_DATA, 7, 8'h40, 8'h01, 8'h01);
    t(CMD_READ_DATA, 8, 8'h40, 8'h00, 8'h40);
    t(CMD_READ_DELETED, 9, 8'h40, 8'h00, 8'h40);
    t(CMD_READ_DATA, 9, 8'h00, 8'h00, 8'h00);
    t(CMD_READ_DATA, 10, 8'h40, 8'h00, 8'h10);
    t(CMD_READ_DATA, 11, 8'h40, 8'h00, 8'h12);
    t(CMD_READ_DATA, 20, 8'h00, 8'h00, 8'h00);
    t(CMD_WRITE_DATA, 12, 8'h40, 8'h02, 8'h00);
    t(CMD_FORMAT, 12, 8'h40, 8'h02, 8'h00);
    t(CMD_READ_DATA, 13, 8'h40, 8'h01, 8'h00);
    t(CMD_READ_DATA, 21, 8'h40, 8'h80, 8'h00);
    t(CMD_READ_DATA, 23, 8'h40, 8'h80, 8'h00);
    t(CMD_READ_DATA, 24, 8'h00, 8'h00, 8'h00);
    t(CMD_READ_DATA, 25, 8'h00, 8'h00, 8'h00);
    t(CMD_WRITE_DELETED, 12, 8'h40, 8'h02, 8'h00);
    t(CMD_WRITE_DATA, 21, 8'h40, 8'h80, 8'h00);
    t(CMD_SEEK, 14, 8'h20, 8'h00, 8'h00);
    t(CMD_SENSE_INT, 0, 8'h20, 8'h00, 8'h00);
    t(CMD_RECAL, 15, 8'h50, 8'h00, 8'h00);
    t(CMD_RECAL, 16, 8'h00, 8'h00, 8'h00);
    t(CMD_REL_SEEK, 17, 8'h50, 8'h00, 8'h00);
    t(CMD_OTHER, 18, 8'h80, 8'h00, 8'h00);
    t(CMD_OTHER, 19, 8'hC0, 8'h00, 8'h00);
    t(CMD_READ_DATA, 22, 8'h00, 8'h00, 8'h00);
    result_count_i = 2'h1;
    t(CMD_SEEK, 14, 8'h20, 8'h00, 8'h00);
    give_verdict;
  end
endmodule

`default_nettype wire
